// *** pkg/instr_dec_pkg.sv ***
package instr_dec_pkg;

	typedef enum logic [5:0] {
		OP_NOP, OP_ADD, OP_ADDC, OP_AND, OP_OR, OP_XOR, OP_COMP,
		OP_CMP_LT, OP_CMP_EQ, OP_CMP_GT, OP_DEC_SZ, OP_INC_SZ, OP_DEC_SNZ, OP_INC_SNZ,
		OP_RLC, OP_RRC, OP_RLN, OP_RRN, OP_SUB, OP_SUBB, OP_SUBFB, OP_MUL,
		OP_CLR, OP_SET, OP_NEG, OP_STORE, OP_BYTE_OTHER, OP_MOVE, OP_JUMP, OP_CALL,
		OP_REL_BRANCH, OP_BCOND, OP_BIT_MOD, OP_BIT_TEST, OP_LITERAL, OP_OTHER
	} op_e;

	typedef enum logic [1:0] {
		WAIT_NONE, WAIT_MOVE, WAIT_JUMP, WAIT_CALL
	} wait_e;

	// Field positions of a 16-bit word
	localparam int DEST_BIT = 9;
	localparam int ACCESS_BIT = 8;
	localparam int FAST_BIT = 8;

	// Prefixes
	localparam logic [3:0] PFX_SECOND = 4'hF;
	localparam logic [3:0] PFX_MOVE = 4'hC;
	localparam logic [3:0] PFX_BIT_CLR = 4'h9;
	localparam logic [3:0] PFX_BIT_SET = 4'h8;
	localparam logic [3:0] PFX_BIT_TOG = 4'h7;
	localparam logic [3:0] PFX_BIT_TSC = 4'hB;
	localparam logic [3:0] PFX_BIT_TSS = 4'hA;
	localparam logic [4:0] PFX_REL_BRANCH = 5'h1A;
	localparam logic [4:0] PFX_BCOND = 5'h1C;
	localparam logic [4:0] PFX_LITERAL = 5'h01;
	localparam logic [6:0] PFX_CALL = 7'h76;
	localparam logic [7:0] PFX_JUMP = 8'hEF;

	// Six-bit byte opcodes
	localparam logic [5:0] OPC_ADD = 6'h09;
	localparam logic [5:0] OPC_ADDC = 6'h08;
	localparam logic [5:0] OPC_OR = 6'h04;
	localparam logic [5:0] OPC_AND = 6'h05;
	localparam logic [5:0] OPC_XOR = 6'h06;
	localparam logic [5:0] OPC_COMP = 6'h07;
	localparam logic [5:0] OPC_DEC_SZ = 6'h0B;
	localparam logic [5:0] OPC_INC_SZ = 6'h0F;
	localparam logic [5:0] OPC_DEC_SNZ = 6'h13;
	localparam logic [5:0] OPC_INC_SNZ = 6'h12;
	localparam logic [5:0] OPC_RLC = 6'h0D;
	localparam logic [5:0] OPC_RRC = 6'h0C;
	localparam logic [5:0] OPC_RLN = 6'h11;
	localparam logic [5:0] OPC_RRN = 6'h10;
	localparam logic [5:0] OPC_SUB = 6'h17;
	localparam logic [5:0] OPC_SUBB = 6'h16;
	localparam logic [5:0] OPC_SUBFB = 6'h15;
	localparam logic [5:0] OPC_DECF = 6'h01;
	localparam logic [5:0] OPC_INCF = 6'h0A;
	localparam logic [5:0] OPC_MOVF = 6'h14;
	localparam logic [5:0] OPC_SWAP = 6'h0E;

	// Seven-bit byte opcodes
	localparam logic [6:0] OPC_MUL = 7'h01;
	localparam logic [6:0] OPC_CMP_LT = 7'h30;
	localparam logic [6:0] OPC_CMP_EQ = 7'h31;
	localparam logic [6:0] OPC_CMP_GT = 7'h32;
	localparam logic [6:0] OPC_TEST = 7'h33;
	localparam logic [6:0] OPC_SET = 7'h34;
	localparam logic [6:0] OPC_CLR = 7'h35;
	localparam logic [6:0] OPC_NEG = 7'h36;
	localparam logic [6:0] OPC_STORE = 7'h37;

	// Flag mask bits {carry, digit carry, zero, overflow, negative}
	localparam logic [4:0] FLG_NONE = 5'h00;
	localparam logic [4:0] FLG_ALL = 5'h1F;
	localparam logic [4:0] FLG_ZN = 5'h05;
	localparam logic [4:0] FLG_CZN = 5'h15;
	localparam logic [4:0] FLG_Z = 5'h04;

	localparam logic [1:0] CYC_ONE = 2'h1;
	localparam logic [1:0] CYC_TWO = 2'h2;

	// Access bank layout and special register addresses
	localparam logic [7:0] ACCESS_SPLIT_DEF = 8'h80;
	localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
	localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
	localparam logic [11:0] PORT_FIRST_DEF = 12'hF80;
	localparam logic [11:0] PORT_LAST_DEF = 12'hF87;
	localparam logic [11:0] TIMER_ADDR_DEF = 12'hFD0;

endpackage

// *** pkg/instr_fields_if.sv ***
interface instr_fields_if;
	logic [15:0] word;
	logic [3:0] prefix;
	logic [5:0] opcode;
	logic dest;
	logic access;
	logic fast;
	logic [7:0] faddr;
	logic [2:0] bitpos;
	logic [7:0] literal;
	logic [10:0] off11;
	logic [7:0] off8;
	logic [11:0] addr12;

	modport src(input word, output prefix, output opcode, output dest, output access,
		output fast, output faddr, output bitpos, output literal, output off11,
		output off8, output addr12);
	modport sink(output word, input prefix, input opcode, input dest, input access,
		input fast, input faddr, input bitpos, input literal, input off11,
		input off8, input addr12);
endinterface

// *** rtl/instr_field_splitter.sv ***
module instr_field_splitter (
	instr_fields_if.src fi
);
	assign fi.prefix = fi.word[15:12];
	assign fi.opcode = fi.word[15:10];
	assign fi.dest = fi.word[instr_dec_pkg::DEST_BIT];
	assign fi.access = fi.word[instr_dec_pkg::ACCESS_BIT];
	assign fi.fast = fi.word[instr_dec_pkg::FAST_BIT];
	assign fi.faddr = fi.word[7:0];
	assign fi.bitpos = fi.word[11:9];
	assign fi.literal = fi.word[7:0];
	assign fi.off11 = fi.word[10:0];
	assign fi.off8 = fi.word[7:0];
	assign fi.addr12 = fi.word[11:0];
endmodule

// *** rtl/bank_resolver.sv ***
module bank_resolver #(
	parameter logic [7:0] ACCESS_SPLIT = instr_dec_pkg::ACCESS_SPLIT_DEF
) (
	input wire logic access,
	input wire logic [7:0] faddr,
	input wire logic [3:0] bank_sel,
	output logic [11:0] eff_addr
);
	// Access bank: low half maps to the bottom bank, upper half to the special bank
	always_comb begin
		if (access) begin
			eff_addr = {bank_sel, faddr};
		end else if (faddr >= ACCESS_SPLIT) begin
			eff_addr = {instr_dec_pkg::ACCESS_HI_BANK, faddr};
		end else begin
			eff_addr = {instr_dec_pkg::ACCESS_LO_BANK, faddr};
		end
	end
endmodule

// *** rtl/byte_op_instruction_decoder.sv ***
module byte_op_instruction_decoder #(
	parameter logic [7:0] ACCESS_SPLIT = instr_dec_pkg::ACCESS_SPLIT_DEF,
	parameter logic [11:0] PORT_FIRST = instr_dec_pkg::PORT_FIRST_DEF,
	parameter logic [11:0] PORT_LAST = instr_dec_pkg::PORT_LAST_DEF,
	parameter logic [11:0] TIMER_ADDR = instr_dec_pkg::TIMER_ADDR_DEF
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [15:0] instr_word,
	input wire logic instr_valid,
	input wire logic [3:0] bank_sel,
	input wire logic cond_true,
	input wire logic prescaler_assigned,
	output logic dec_valid,
	output instr_dec_pkg::op_e op,
	output logic second_word,
	output logic dest_is_reg,
	output logic access_bank,
	output logic [7:0] file_addr,
	output logic [11:0] eff_addr,
	output logic [2:0] bit_pos,
	output logic [7:0] literal,
	output logic [10:0] branch_offset,
	output logic [19:0] target_addr,
	output logic fast_call,
	output logic [11:0] src_addr,
	output logic [11:0] dst_addr,
	output logic [4:0] flags_mask,
	output logic [1:0] base_cycles,
	output logic may_skip,
	output logic use_pin_levels,
	output logic prescaler_clear
);

	////////////////////////////////////////////////////////////////////////////////

	typedef struct packed {
		logic dec_valid;
		instr_dec_pkg::op_e op;
		logic second_word;
		logic dest_is_reg;
		logic access_bank;
		logic [7:0] file_addr;
		logic [11:0] eff_addr;
		logic [2:0] bit_pos;
		logic [7:0] literal;
		logic [10:0] branch_offset;
		logic [19:0] target_addr;
		logic fast_call;
		logic [11:0] src_addr;
		logic [11:0] dst_addr;
		logic [4:0] flags_mask;
		logic [1:0] base_cycles;
		logic may_skip;
		logic use_pin_levels;
		logic prescaler_clear;
		instr_dec_pkg::wait_e wait_kind;
		logic pending_nop;
	} state_s;

	state_s st_r;
	state_s st_nxt;
	logic [11:0] eff_now;
	logic nop_now;
	instr_dec_pkg::op_e op_now;
	logic writes_now;

	instr_fields_if fi ();

	assign fi.word = instr_word;

	instr_field_splitter u_split (
		.fi(fi.src)
	);

	bank_resolver #(
		.ACCESS_SPLIT(ACCESS_SPLIT)
	) u_bank (
		.access(fi.access),
		.faddr(fi.faddr),
		.bank_sel(bank_sel),
		.eff_addr(eff_now)
	);

	////////////////////////////////////////////////////////////////////////////////

	function automatic instr_dec_pkg::op_e decode_op(input logic [15:0] w);
		instr_dec_pkg::op_e r;
		r = instr_dec_pkg::OP_OTHER;
		if (w[15:12] == instr_dec_pkg::PFX_SECOND) begin
			r = instr_dec_pkg::OP_NOP;
		end else if (w[15:12] == instr_dec_pkg::PFX_MOVE) begin
			r = instr_dec_pkg::OP_MOVE;
		end else if (w[15:8] == instr_dec_pkg::PFX_JUMP) begin
			r = instr_dec_pkg::OP_JUMP;
		end else if (w[15:9] == instr_dec_pkg::PFX_CALL) begin
			r = instr_dec_pkg::OP_CALL;
		end else if (w[15:11] == instr_dec_pkg::PFX_REL_BRANCH) begin
			r = instr_dec_pkg::OP_REL_BRANCH;
		end else if (w[15:11] == instr_dec_pkg::PFX_BCOND) begin
			r = instr_dec_pkg::OP_BCOND;
		end else if (w[15:12] == instr_dec_pkg::PFX_BIT_CLR
				|| w[15:12] == instr_dec_pkg::PFX_BIT_SET
				|| w[15:12] == instr_dec_pkg::PFX_BIT_TOG) begin
			r = instr_dec_pkg::OP_BIT_MOD;
		end else if (w[15:12] == instr_dec_pkg::PFX_BIT_TSC
				|| w[15:12] == instr_dec_pkg::PFX_BIT_TSS) begin
			r = instr_dec_pkg::OP_BIT_TEST;
		end else if (w[15:11] == instr_dec_pkg::PFX_LITERAL) begin
			r = instr_dec_pkg::OP_LITERAL;
		end else if (w[15:9] == instr_dec_pkg::OPC_MUL) begin
			r = instr_dec_pkg::OP_MUL;
		end else if (w[15:9] == instr_dec_pkg::OPC_CMP_LT) begin
			r = instr_dec_pkg::OP_CMP_LT;
		end else if (w[15:9] == instr_dec_pkg::OPC_CMP_EQ) begin
			r = instr_dec_pkg::OP_CMP_EQ;
		end else if (w[15:9] == instr_dec_pkg::OPC_CMP_GT) begin
			r = instr_dec_pkg::OP_CMP_GT;
		end else if (w[15:9] == instr_dec_pkg::OPC_CLR) begin
			r = instr_dec_pkg::OP_CLR;
		end else if (w[15:9] == instr_dec_pkg::OPC_SET) begin
			r = instr_dec_pkg::OP_SET;
		end else if (w[15:9] == instr_dec_pkg::OPC_NEG) begin
			r = instr_dec_pkg::OP_NEG;
		end else if (w[15:9] == instr_dec_pkg::OPC_STORE) begin
			r = instr_dec_pkg::OP_STORE;
		end else if (w[15:9] == instr_dec_pkg::OPC_TEST) begin
			r = instr_dec_pkg::OP_BYTE_OTHER;
		end else begin
			case (w[15:10])
				instr_dec_pkg::OPC_ADD: r = instr_dec_pkg::OP_ADD;
				instr_dec_pkg::OPC_ADDC: r = instr_dec_pkg::OP_ADDC;
				instr_dec_pkg::OPC_OR: r = instr_dec_pkg::OP_OR;
				instr_dec_pkg::OPC_AND: r = instr_dec_pkg::OP_AND;
				instr_dec_pkg::OPC_XOR: r = instr_dec_pkg::OP_XOR;
				instr_dec_pkg::OPC_COMP: r = instr_dec_pkg::OP_COMP;
				instr_dec_pkg::OPC_DEC_SZ: r = instr_dec_pkg::OP_DEC_SZ;
				instr_dec_pkg::OPC_INC_SZ: r = instr_dec_pkg::OP_INC_SZ;
				instr_dec_pkg::OPC_DEC_SNZ: r = instr_dec_pkg::OP_DEC_SNZ;
				instr_dec_pkg::OPC_INC_SNZ: r = instr_dec_pkg::OP_INC_SNZ;
				instr_dec_pkg::OPC_RLC: r = instr_dec_pkg::OP_RLC;
				instr_dec_pkg::OPC_RRC: r = instr_dec_pkg::OP_RRC;
				instr_dec_pkg::OPC_RLN: r = instr_dec_pkg::OP_RLN;
				instr_dec_pkg::OPC_RRN: r = instr_dec_pkg::OP_RRN;
				instr_dec_pkg::OPC_SUB: r = instr_dec_pkg::OP_SUB;
				instr_dec_pkg::OPC_SUBB: r = instr_dec_pkg::OP_SUBB;
				instr_dec_pkg::OPC_SUBFB: r = instr_dec_pkg::OP_SUBFB;
				instr_dec_pkg::OPC_DECF, instr_dec_pkg::OPC_INCF,
				instr_dec_pkg::OPC_MOVF, instr_dec_pkg::OPC_SWAP: begin
					r = instr_dec_pkg::OP_BYTE_OTHER;
				end
				default: r = instr_dec_pkg::OP_OTHER;
			endcase
		end
		return r;
	endfunction

	// Only the ops in this block's scope get a mask; the rest are owned elsewhere
	function automatic logic [4:0] flag_mask(input instr_dec_pkg::op_e o);
		logic [4:0] m;
		m = instr_dec_pkg::FLG_NONE;
		case (o)
			instr_dec_pkg::OP_ADD, instr_dec_pkg::OP_ADDC: m = instr_dec_pkg::FLG_ALL;
			instr_dec_pkg::OP_SUB, instr_dec_pkg::OP_SUBB,
			instr_dec_pkg::OP_SUBFB: m = instr_dec_pkg::FLG_ALL;
			instr_dec_pkg::OP_NEG: m = instr_dec_pkg::FLG_ALL;
			instr_dec_pkg::OP_CLR: m = instr_dec_pkg::FLG_Z;
			instr_dec_pkg::OP_OR, instr_dec_pkg::OP_AND,
			instr_dec_pkg::OP_COMP: m = instr_dec_pkg::FLG_ZN;
			instr_dec_pkg::OP_RLC, instr_dec_pkg::OP_RRC: m = instr_dec_pkg::FLG_CZN;
			instr_dec_pkg::OP_RLN, instr_dec_pkg::OP_RRN: m = instr_dec_pkg::FLG_ZN;
			default: m = instr_dec_pkg::FLG_NONE;
		endcase
		return m;
	endfunction

	function automatic logic is_skip(input instr_dec_pkg::op_e o);
		return o == instr_dec_pkg::OP_CMP_LT || o == instr_dec_pkg::OP_CMP_EQ
			|| o == instr_dec_pkg::OP_CMP_GT || o == instr_dec_pkg::OP_DEC_SZ
			|| o == instr_dec_pkg::OP_INC_SZ || o == instr_dec_pkg::OP_DEC_SNZ
			|| o == instr_dec_pkg::OP_INC_SNZ || o == instr_dec_pkg::OP_BIT_TEST;
	endfunction

	// Ops that honour the destination bit
	function automatic logic has_dest(input instr_dec_pkg::op_e o);
		return (o >= instr_dec_pkg::OP_ADD && o <= instr_dec_pkg::OP_COMP)
			|| (o >= instr_dec_pkg::OP_DEC_SZ && o <= instr_dec_pkg::OP_SUBFB)
			|| o == instr_dec_pkg::OP_BYTE_OTHER;
	endfunction

	// Ops that always write the file register
	function automatic logic fixed_reg_write(input instr_dec_pkg::op_e o);
		return o == instr_dec_pkg::OP_CLR || o == instr_dec_pkg::OP_SET
			|| o == instr_dec_pkg::OP_NEG || o == instr_dec_pkg::OP_STORE
			|| o == instr_dec_pkg::OP_BIT_MOD;
	endfunction

	////////////////////////////////////////////////////////////////////////////////

	assign op_now = decode_op(instr_word);
	assign writes_now = (has_dest(op_now) && fi.dest) || fixed_reg_write(op_now);
	assign nop_now = st_r.pending_nop || cond_true;

	always_comb begin
		st_nxt = st_r;
		st_nxt.dec_valid = 1'b0;
		st_nxt.use_pin_levels = 1'b0;
		st_nxt.prescaler_clear = 1'b0;
		if (instr_valid) begin
			st_nxt.dec_valid = 1'b1;
			st_nxt.pending_nop = 1'b0;
			st_nxt.access_bank = fi.access;
			st_nxt.file_addr = fi.faddr;
			st_nxt.eff_addr = eff_now;
			st_nxt.bit_pos = fi.bitpos;
			st_nxt.literal = fi.literal;
			if (nop_now) begin
				// Flushed word: a skipped first word also drops its pairing
				st_nxt.op = instr_dec_pkg::OP_NOP;
				st_nxt.second_word = 1'b0;
				st_nxt.dest_is_reg = 1'b0;
				st_nxt.flags_mask = instr_dec_pkg::FLG_NONE;
				st_nxt.base_cycles = instr_dec_pkg::CYC_ONE;
				st_nxt.may_skip = 1'b0;
				st_nxt.wait_kind = instr_dec_pkg::WAIT_NONE;
			end else if (st_r.wait_kind != instr_dec_pkg::WAIT_NONE
					&& fi.prefix == instr_dec_pkg::PFX_SECOND) begin
				st_nxt.second_word = 1'b1;
				st_nxt.dest_is_reg = 1'b0;
				st_nxt.flags_mask = instr_dec_pkg::FLG_NONE;
				st_nxt.base_cycles = instr_dec_pkg::CYC_TWO;
				st_nxt.may_skip = 1'b0;
				st_nxt.wait_kind = instr_dec_pkg::WAIT_NONE;
				if (st_r.wait_kind == instr_dec_pkg::WAIT_MOVE) begin
					st_nxt.op = instr_dec_pkg::OP_MOVE;
					st_nxt.dst_addr = fi.addr12;
				end else begin
					st_nxt.op = (st_r.wait_kind == instr_dec_pkg::WAIT_CALL)
						? instr_dec_pkg::OP_CALL : instr_dec_pkg::OP_JUMP;
					st_nxt.target_addr = {fi.addr12, st_r.target_addr[7:0]};
					st_nxt.pending_nop = 1'b1;
				end
			end else begin
				st_nxt.op = op_now;
				st_nxt.second_word = 1'b0;
				st_nxt.dest_is_reg = writes_now;
				st_nxt.flags_mask = flag_mask(op_now);
				st_nxt.may_skip = is_skip(op_now);
				st_nxt.base_cycles = instr_dec_pkg::CYC_ONE;
				st_nxt.wait_kind = instr_dec_pkg::WAIT_NONE;
				if (op_now == instr_dec_pkg::OP_BCOND) begin
					st_nxt.branch_offset = {{3{fi.off8[7]}}, fi.off8};
				end else begin
					st_nxt.branch_offset = fi.off11;
				end
				case (op_now)
					instr_dec_pkg::OP_MOVE: begin
						st_nxt.src_addr = fi.addr12;
						st_nxt.base_cycles = instr_dec_pkg::CYC_TWO;
						st_nxt.wait_kind = instr_dec_pkg::WAIT_MOVE;
					end
					instr_dec_pkg::OP_JUMP: begin
						st_nxt.target_addr = {12'h000, fi.literal};
						st_nxt.base_cycles = instr_dec_pkg::CYC_TWO;
						st_nxt.wait_kind = instr_dec_pkg::WAIT_JUMP;
					end
					instr_dec_pkg::OP_CALL: begin
						st_nxt.target_addr = {12'h000, fi.literal};
						st_nxt.fast_call = fi.fast;
						st_nxt.base_cycles = instr_dec_pkg::CYC_TWO;
						st_nxt.wait_kind = instr_dec_pkg::WAIT_CALL;
					end
					instr_dec_pkg::OP_REL_BRANCH: begin
						st_nxt.base_cycles = instr_dec_pkg::CYC_TWO;
						st_nxt.pending_nop = 1'b1;
					end
					default: begin
						st_nxt.base_cycles = instr_dec_pkg::CYC_ONE;
					end
				endcase
				// Clear, set and store overwrite without reading, so no pin read
				if (writes_now && op_now != instr_dec_pkg::OP_CLR
						&& op_now != instr_dec_pkg::OP_SET
						&& op_now != instr_dec_pkg::OP_STORE
						&& eff_now >= PORT_FIRST && eff_now <= PORT_LAST) begin
					st_nxt.use_pin_levels = 1'b1;
				end
				if (writes_now && eff_now == TIMER_ADDR && prescaler_assigned) begin
					st_nxt.prescaler_clear = 1'b1;
				end
			end
		end else if (cond_true) begin
			// Test result arrived between fetches: hold it for the next word
			st_nxt.pending_nop = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	assign dec_valid = st_r.dec_valid;
	assign op = st_r.op;
	assign second_word = st_r.second_word;
	assign dest_is_reg = st_r.dest_is_reg;
	assign access_bank = st_r.access_bank;
	assign file_addr = st_r.file_addr;
	assign eff_addr = st_r.eff_addr;
	assign bit_pos = st_r.bit_pos;
	assign literal = st_r.literal;
	assign branch_offset = st_r.branch_offset;
	assign target_addr = st_r.target_addr;
	assign fast_call = st_r.fast_call;
	assign src_addr = st_r.src_addr;
	assign dst_addr = st_r.dst_addr;
	assign flags_mask = st_r.flags_mask;
	assign base_cycles = st_r.base_cycles;
	assign may_skip = st_r.may_skip;
	assign use_pin_levels = st_r.use_pin_levels;
	assign prescaler_clear = st_r.prescaler_clear;

	////////////////////////////////////////////////////////////////////////////////

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	AST_DEST_SEL: assert property (dec_valid && op == instr_dec_pkg::OP_ADD
		|-> dest_is_reg == $past(instr_word[9]))
		else $error("destination select not taken from bit 9");
	AST_BANK_SEL: assert property (dec_valid && access_bank
		|-> eff_addr == {$past(bank_sel), file_addr})
		else $error("banked address not built from bank select");
	AST_ACCESS_RAM: assert property (dec_valid && !access_bank
		|-> eff_addr[7:0] == file_addr && (eff_addr[11:8] == instr_dec_pkg::ACCESS_LO_BANK
		|| eff_addr[11:8] == instr_dec_pkg::ACCESS_HI_BANK))
		else $error("access address leaves the access bank");
	AST_FILE_FIELD: assert property (dec_valid && !second_word
		|-> file_addr == $past(instr_word[7:0]) && bit_pos == $past(instr_word[11:9]))
		else $error("file address or bit position field wrong");
	AST_MOVE_DEST: assert property (dec_valid && second_word
		&& op == instr_dec_pkg::OP_MOVE |-> dst_addr == $past(instr_word[11:0])
		&& base_cycles == instr_dec_pkg::CYC_TWO)
		else $error("move destination address wrong");
	AST_TARGET_HI: assert property (dec_valid && second_word && (op == instr_dec_pkg::OP_JUMP
		|| op == instr_dec_pkg::OP_CALL) |-> target_addr[19:8] == $past(instr_word[11:0])
		&& target_addr[7:0] == $past(target_addr[7:0]))
		else $error("jump target upper bits wrong");
	AST_REL_OFFSET: assert property (dec_valid && op == instr_dec_pkg::OP_REL_BRANCH
		|-> branch_offset == $past(instr_word[10:0]))
		else $error("relative branch offset wrong");
	AST_BCOND_OFFSET: assert property (dec_valid && op == instr_dec_pkg::OP_BCOND
		|-> branch_offset == {{3{$past(instr_word[7])}}, $past(instr_word[7:0])})
		else $error("conditional branch offset not sign extended");
	AST_ADD_FLAGS: assert property (dec_valid && (op == instr_dec_pkg::OP_ADD
		|| op == instr_dec_pkg::OP_SUB) |-> flags_mask == instr_dec_pkg::FLG_ALL)
		else $error("add or subtract flag mask wrong");
	AST_MUL_QUIET: assert property (dec_valid && op == instr_dec_pkg::OP_MUL
		|-> flags_mask == instr_dec_pkg::FLG_NONE && base_cycles == instr_dec_pkg::CYC_ONE)
		else $error("multiply must be one cycle with no flags");
	AST_REL_NOP: assert property (dec_valid && op == instr_dec_pkg::OP_REL_BRANCH
		&& !second_word && instr_valid |=> dec_valid && op == instr_dec_pkg::OP_NOP)
		else $error("word after branch not turned into no-operation");
	AST_LONE_SECOND: assert property (instr_valid
		&& instr_word[15:12] == instr_dec_pkg::PFX_SECOND
		&& st_r.wait_kind == instr_dec_pkg::WAIT_NONE |=> op == instr_dec_pkg::OP_NOP)
		else $error("standalone second word not a no-operation");
	AST_PRESCALE: assert property (prescaler_clear
		|-> eff_addr == TIMER_ADDR && dest_is_reg && $past(prescaler_assigned))
		else $error("prescaler clear without timer write");

endmodule

// *** testbench/prog_mem_model.sv ***
module prog_mem_model (
	input wire logic ref_clk,
	output logic [15:0] instr_word,
	output logic instr_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] q[$];
	initial begin
		instr_word = 16'h0000;
		instr_valid = 1'b0;
	end
	// Idle cycles show a changing pattern, so a stale word can never pass for a fresh one
	always @(negedge ref_clk) begin
		instr_valid <= (q.size() != 0);
		instr_word <= (q.size() != 0) ? q.pop_front() : ~instr_word;
	end
endmodule

// *** testbench/byte_op_instruction_decoder_test.sv ***
module byte_op_instruction_decoder_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk, rst, cond_true, prescaler_assigned, instr_valid, dec_valid, second_word;
	logic dest_is_reg, access_bank, fast_call, use_pin_levels, prescaler_clear, may_skip;
	logic [3:0] bank_sel;
	logic [15:0] instr_word, w;
	instr_dec_pkg::op_e op;
	logic [7:0] file_addr, literal;
	logic [11:0] eff_addr, src_addr, dst_addr, ea;
	logic [2:0] bit_pos;
	logic [10:0] branch_offset;
	logic [19:0] target_addr;
	logic [4:0] flags_mask;
	logic [1:0] base_cycles;
	logic [32:0] expq[$];
	logic [32:0] e;
	logic [23:0] act, t, v;
	logic [31:0] r;
	int bad_count = 0;
	int total_checks = 0;
	int cycles = 0;
	// Entry: op code number, {d free, word bits 15:9}, {skips, fixed destination, flag mask}
	logic [23:0] tbl [25] = '{24'h01921F, 24'h02901F, 24'h038A05, 24'h048805, 24'h058C00,
		24'h068E05, 24'h073040, 24'h083140, 24'h093240, 24'h0A9640, 24'h0B9E40, 24'h0CA640,
		24'h0DA440, 24'h0E9A15, 24'h0F9815, 24'h10A205, 24'h11A005, 24'h12AE1F, 24'h13AC1F,
		24'h14AA1F, 24'h150100, 24'h163524, 24'h173420, 24'h18363F, 24'h193720};

	prog_mem_model i_prog_mem_model (.ref_clk, .instr_word, .instr_valid);
	byte_op_instruction_decoder i_byte_op_instruction_decoder (.ref_clk, .rst, .instr_word,
		.instr_valid, .bank_sel, .cond_true, .prescaler_assigned, .dec_valid, .op,
		.second_word, .dest_is_reg, .access_bank, .file_addr, .eff_addr, .bit_pos, .literal,
		.branch_offset, .target_addr, .fast_call, .src_addr, .dst_addr, .flags_mask,
		.base_cycles, .may_skip, .use_pin_levels, .prescaler_clear);

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	// Selector picks which output group is compared beside the operation
	task automatic issue(input logic [15:0] iw, input logic [3:0] b, input logic c,
		input logic [5:0] o, input logic [2:0] s, input logic [23:0] v);
		@(posedge ref_clk);
		i_prog_mem_model.q.push_back(iw);
		expq.push_back({o, s, v});
		@(negedge ref_clk);
		bank_sel = b;
		cond_true = c;
	endtask

	always @(negedge ref_clk) begin
		cycles++;
		if (cycles > 1000) begin
			bad_count++;
			end_of_test();
		end else if (dec_valid === 1'b1) begin
			e = (expq.size() != 0) ? expq.pop_front() : '1;
			case (e[26:24])
				3'd0: act = {2'h0, access_bank, may_skip, base_cycles, flags_mask, dest_is_reg, eff_addr};
				3'd1: act = {2'h0, base_cycles, target_addr};
				3'd2: act = {1'b0, base_cycles, fast_call, target_addr};
				3'd3: act = {10'h000, base_cycles, src_addr};
				3'd4: act = {10'h000, base_cycles, dst_addr};
				3'd5: act = {11'h000, base_cycles, branch_offset};
				3'd6: act = {13'h0000, bit_pos, literal};
				default: act = {12'h000, may_skip, file_addr, use_pin_levels, prescaler_clear, second_word};
			endcase
			total_checks++;
			if (op !== instr_dec_pkg::op_e'(e[32:27]) || act !== e[23:0]) begin
				bad_count++;
				$display("[ERR] %0t op %0d got %h want %h", $time, op, act, e[23:0]);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		bank_sel = 4'h0;
		cond_true = 1'b0;
		prescaler_assigned = 1'b1;
		void'($urandom(32'hEA5C3EB1));
		repeat (2) @(negedge ref_clk);
		rst = 1'b0;
		for (int i = 0; i < 50; i++) begin
			t = tbl[i % 25];
			r = $urandom;
			w = {t[14:8] | {6'h00, t[15] & r[0]}, r[1], r[9:2]};
			ea = r[1] ? {r[13:10], r[9:2]} : {{4{r[9]}}, r[9:2]};
			v = {2'h0, r[1], t[6], instr_dec_pkg::CYC_ONE, t[4:0], t[15] ? r[0] : t[5], ea};
			issue(w, r[13:10], 1'b0, t[21:16], 3'd0, v);
		end
		issue(16'hC123, 4'h0, 1'b0, 6'd27, 3'd3, 24'h002123);
		issue(16'hF456, 4'h0, 1'b0, 6'd27, 3'd4, 24'h002456);
		issue(16'hEF34, 4'h0, 1'b0, 6'd28, 3'd1, 24'h200034);
		issue(16'hF012, 4'h0, 1'b0, 6'd28, 3'd1, 24'h201234);
		issue(16'h0E7F, 4'h0, 1'b0, 6'd0, 3'd7, 24'h0003F8);
		issue(16'hED56, 4'h0, 1'b0, 6'd29, 3'd2, 24'h500056);
		issue(16'hF789, 4'h0, 1'b0, 6'd29, 3'd2, 24'h578956);
		issue(16'h0E7F, 4'h0, 1'b0, 6'd0, 3'd7, 24'h0003F8);
		issue(16'hFABC, 4'h0, 1'b0, 6'd0, 3'd7, 24'h0005E0);
		issue(16'h0E7F, 4'h0, 1'b0, 6'd34, 3'd6, 24'h00077F);
		issue(16'h9B45, 4'h0, 1'b0, 6'd32, 3'd6, 24'h000545);
		issue(16'hD7FF, 4'h0, 1'b0, 6'd30, 3'd5, 24'h0017FF);
		issue(16'h0E7F, 4'h0, 1'b0, 6'd0, 3'd7, 24'h0003F8);
		issue(16'hE280, 4'h0, 1'b0, 6'd31, 3'd5, 24'h000F80);
		issue(16'h6201, 4'h0, 1'b0, 6'd8, 3'd7, 24'h000808);
		issue(16'h0E7F, 4'h0, 1'b1, 6'd0, 3'd7, 24'h0003F8);
		issue(16'h2680, 4'h0, 1'b0, 6'd1, 3'd7, 24'h000404);
		issue(16'h5ED0, 4'h0, 1'b0, 6'd18, 3'd7, 24'h000682);
		// Test result with no word in flight must flush the next word
		@(negedge ref_clk);
		prescaler_assigned = 1'b0;
		cond_true = 1'b1;
		issue(16'h5ED0, 4'h0, 1'b0, 6'd0, 3'd7, 24'h000680);
		issue(16'h5ED0, 4'h0, 1'b0, 6'd18, 3'd7, 24'h000680);
		repeat (4) @(negedge ref_clk);
		if (expq.size() != 0) begin
			bad_count++;
			$display("[ERR] %0t decodes missing %0d", $time, expq.size());
		end
		end_of_test();
	end
endmodule
